// ### src/uiec_pkg.sv
// Package for the IN endpoint control block: register indices, field positions,
// reset values, reply codes and slot counts.
// Assumes an AHB-Lite bus with 32-bit words, registers at byte address = 4 * index.
//
// Overview of operation
// - Isochronous: zero-length reply to IN with nothing ready sets underrun.
// - Bulk or interrupt: every NAK to an IN token sets underrun.
// - Underrun stays set until firmware clears it; hardware never clears it.
// - FIFO-has-packet reads 0 when empty, 1 with one or more packets.
// - Packet-loaded clears after the loaded packet has gone to the host.
// - Double buffered with a free slot: packet-loaded clears at once.
// - Isochronous with update hold: packet-loaded reads 0 until next frame start.
// - Enabled endpoint interrupt fires when a sent packet clears packet-loaded.
// - High byte bit 7: double buffering off at 0, on at 1.
// - High byte bit 6: bulk/interrupt at 0, isochronous at 1.
// - High byte bit 5: OUT at 0, IN at 1; only while not split.
// - Bit 3 at 0: toggle advances on ACK; at 1: after every packet.
// - Split bit 2 at 1: upper FIFO half to IN, lower half to OUT.
// - High byte bit 4 and bits 1:0 read zero, writes ignored.
// - Every bit of the high control byte resets to 0.
// - Sent STALL sets stall flag, flushes FIFO, clears packet-loaded; firmware clears flag.
package uiec_pkg;

  localparam logic [7:0] UIEC_IDX_CTRL_LOW = 8'h11;
  localparam logic [7:0] UIEC_IDX_CTRL_HIGH = 8'h12;
  localparam logic [7:0] UIEC_IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] UIEC_IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] UIEC_IDX_OPTIONS = 8'h22;

  // Low byte fields
  localparam int UIEC_LO_LOADED = 0;
  localparam int UIEC_LO_HAS_PKT = 1;
  localparam int UIEC_LO_UNDERRUN = 2;
  localparam int UIEC_LO_SEND_STALL = 4;
  localparam int UIEC_LO_STALL_SENT = 5;
  localparam int UIEC_LO_CLEAR_TOGGLE = 6;

  // High byte fields
  localparam int UIEC_HI_DOUBLE = 7;
  localparam int UIEC_HI_ISO = 6;
  localparam int UIEC_HI_DIR = 5;
  localparam int UIEC_HI_FORCE = 3;
  localparam int UIEC_HI_SPLIT = 2;
  localparam logic [7:0] UIEC_HI_RESET = 8'h00;

  // Options register and interrupt bits
  localparam int UIEC_OPT_HOLD = 0;
  localparam int UIEC_IRQ_SENT = 0;
  localparam int UIEC_IRQ_UNDERRUN = 1;
  localparam int UIEC_IRQ_STALL = 2;
  localparam int UIEC_IRQ_BITS = 3;

  localparam logic [1:0] UIEC_SLOTS_SINGLE = 2'h1;
  localparam logic [1:0] UIEC_SLOTS_DOUBLE = 2'h2;

  typedef enum logic [1:0] {
    UIEC_REPLY_DATA = 2'b00,
    UIEC_REPLY_ZLP = 2'b01,
    UIEC_REPLY_NAK = 2'b10,
    UIEC_REPLY_STALL = 2'b11
  } uiec_reply_type;

endpackage

// ### src/uiec_in_endpoint.sv
// IN endpoint control and status logic with an AHB-Lite register slave.
// Assumes the serial engine drives token and handshake pulses on this clock,
// and that firmware only issues single word transfers.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module uiec_in_endpoint
  import uiec_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  // Serial engine side
  input wire logic in_token,
  input wire logic ack_received,
  input wire logic ack_timeout,
  input wire logic sof_received,
  output logic reply_valid,
  output uiec_reply_type reply_kind,
  output logic reply_data1,
  output logic endpoint_is_in,
  output logic in_fifo_upper_half,
  output logic fifo_split
);

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_idx;
    logic in_double_buffer_enable;
    logic iso;
    logic endpoint_direction_pick;
    logic force_toggle_always;
    logic split;
    logic periodic_update_hold;
    logic send_stall;
    logic stall_was_sent;
    logic in_underrun_flag;
    logic in_packet_loaded;
    logic hold_pending;
    logic [1:0] pkt_count;
    logic toggle;
    logic await_hs;
    logic [UIEC_IRQ_BITS-1:0] irq_status;
    logic [UIEC_IRQ_BITS-1:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
    logic reply_valid;
    uiec_reply_type reply_kind;
    logic reply_data1;
    logic endpoint_is_in;
    logic in_fifo_upper_half;
    logic fifo_split;
    // Bus answer kept in flops so every output leaves a register
    logic bus_ready;
    logic bus_error;
  } uiec_state_type;

  uiec_state_type cur_ff;
  uiec_state_type nxt_st;

  logic addr_phase;
  logic [7:0] addr_idx;
  logic [7:0] lo_byte;
  logic [7:0] hi_byte;
  logic [1:0] slots;
  logic wr_lo;
  logic wr_hi;
  logic sent_evt;
  logic underrun_evt;
  logic stall_evt;
  logic fw_load;
  logic [UIEC_IRQ_BITS-1:0] irq_set;

  // Write strobes for the remaining registers, all in the data phase
  logic wr_opt;
  logic wr_mask;
  logic wr_stat;
  logic load_ok;

  // Read side: word picked in the address phase
  logic rd_take;
  logic [31:0] rd_word;

  // Token decision, worked out before the state update
  logic tok_take;
  logic tok_stall;
  logic tok_data;
  logic tok_zlp;
  logic tok_nak;

  // Handshake outcome for a pending bulk packet
  logic hs_sent;
  logic hs_retry;

  assign addr_phase = hsel && htrans[1] && hready;
  assign addr_idx = haddr[9:2];

  always_comb begin
    lo_byte = 8'h00;
    lo_byte[UIEC_LO_LOADED] = cur_ff.in_packet_loaded && !cur_ff.hold_pending;
    lo_byte[UIEC_LO_HAS_PKT] = cur_ff.pkt_count != 2'h0;
    lo_byte[UIEC_LO_UNDERRUN] = cur_ff.in_underrun_flag;
    lo_byte[UIEC_LO_SEND_STALL] = cur_ff.send_stall;
    lo_byte[UIEC_LO_STALL_SENT] = cur_ff.stall_was_sent;
    // Unused bits stay zero by construction
    hi_byte = 8'h00;
    hi_byte[UIEC_HI_DOUBLE] = cur_ff.in_double_buffer_enable;
    hi_byte[UIEC_HI_ISO] = cur_ff.iso;
    hi_byte[UIEC_HI_DIR] = cur_ff.endpoint_direction_pick;
    hi_byte[UIEC_HI_FORCE] = cur_ff.force_toggle_always;
    hi_byte[UIEC_HI_SPLIT] = cur_ff.split;
  end

  // Second slot only counts while double buffering is on
  assign slots = cur_ff.in_double_buffer_enable ? UIEC_SLOTS_DOUBLE : UIEC_SLOTS_SINGLE;

  assign wr_lo = cur_ff.wr_pend && (cur_ff.wr_idx == UIEC_IDX_CTRL_LOW);
  assign wr_hi = cur_ff.wr_pend && (cur_ff.wr_idx == UIEC_IDX_CTRL_HIGH);
  assign wr_opt = cur_ff.wr_pend && (cur_ff.wr_idx == UIEC_IDX_OPTIONS);
  assign wr_mask = cur_ff.wr_pend && (cur_ff.wr_idx == UIEC_IDX_IRQ_MASK);
  assign wr_stat = cur_ff.wr_pend && (cur_ff.wr_idx == UIEC_IDX_IRQ_STATUS);

  // A load with the FIFO full is dropped rather than overwriting a queued packet
  assign load_ok = wr_lo && hwdata[UIEC_LO_LOADED] && !cur_ff.in_packet_loaded && (cur_ff.pkt_count < slots);

  assign rd_take = addr_phase && !hwrite;

  // Unmapped indices read zero so firmware probing the map sees nothing stray
  always_comb begin
    unique case (addr_idx)
      UIEC_IDX_CTRL_LOW: rd_word = {24'h000000, lo_byte};
      UIEC_IDX_CTRL_HIGH: rd_word = {24'h000000, hi_byte};
      UIEC_IDX_IRQ_STATUS: rd_word = {29'h00000000, cur_ff.irq_status};
      UIEC_IDX_IRQ_MASK: rd_word = {29'h00000000, cur_ff.irq_mask};
      UIEC_IDX_OPTIONS: rd_word = {31'h00000000, cur_ff.periodic_update_hold};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Tokens arriving while a handshake is owed are ignored, not queued
  always_comb begin
    tok_take = in_token && !cur_ff.await_hs;
    tok_stall = 1'b0;
    tok_data = 1'b0;
    tok_zlp = 1'b0;
    tok_nak = 1'b0;
    if (tok_take) begin
      if (cur_ff.send_stall) begin
        tok_stall = 1'b1;
      end else if (cur_ff.pkt_count != 2'h0) begin
        tok_data = 1'b1;
      end else if (cur_ff.iso) begin
        tok_zlp = 1'b1;
      end else begin
        tok_nak = 1'b1;
      end
    end
  end

  // Missing ACK without forcing keeps packet and PID for the host's retry
  always_comb begin
    hs_sent = 1'b0;
    hs_retry = 1'b0;
    if (cur_ff.await_hs) begin
      if (ack_received) begin
        hs_sent = 1'b1;
      end else if (ack_timeout) begin
        hs_sent = cur_ff.force_toggle_always;
        hs_retry = !cur_ff.force_toggle_always;
      end
    end
  end

  always_comb begin
    nxt_st = cur_ff;
    sent_evt = 1'b0;
    underrun_evt = 1'b0;
    stall_evt = 1'b0;
    fw_load = 1'b0;
    irq_set = '0;
    nxt_st.reply_valid = 1'b0;
    nxt_st.bus_ready = 1'b1;
    nxt_st.bus_error = 1'b0;

    // Bus address phase: capture write target, prepare read data
    nxt_st.wr_pend = addr_phase && hwrite;
    nxt_st.wr_idx = addr_idx;
    if (rd_take) begin
      nxt_st.rdata = rd_word;
    end

    // Bus data phase: register writes
    if (wr_hi) begin
      nxt_st.in_double_buffer_enable = hwdata[UIEC_HI_DOUBLE];
      nxt_st.iso = hwdata[UIEC_HI_ISO];
      nxt_st.endpoint_direction_pick = hwdata[UIEC_HI_DIR];
      nxt_st.force_toggle_always = hwdata[UIEC_HI_FORCE];
      nxt_st.split = hwdata[UIEC_HI_SPLIT];
    end
    if (wr_opt) begin
      nxt_st.periodic_update_hold = hwdata[UIEC_OPT_HOLD];
    end
    if (wr_mask) begin
      nxt_st.irq_mask = hwdata[UIEC_IRQ_BITS-1:0];
    end
    if (wr_lo) begin
      nxt_st.send_stall = hwdata[UIEC_LO_SEND_STALL];
      // Firmware may only clear the sticky flags
      if (!hwdata[UIEC_LO_UNDERRUN]) begin
        nxt_st.in_underrun_flag = 1'b0;
      end
      if (!hwdata[UIEC_LO_STALL_SENT]) begin
        nxt_st.stall_was_sent = 1'b0;
      end
      if (hwdata[UIEC_LO_CLEAR_TOGGLE]) begin
        nxt_st.toggle = 1'b0;
      end
      if (load_ok) begin
        fw_load = 1'b1;
      end
    end

    if (fw_load) begin
      if (cur_ff.iso && cur_ff.periodic_update_hold) begin
        nxt_st.hold_pending = 1'b1;
        nxt_st.in_packet_loaded = 1'b1;
      end else begin
        nxt_st.pkt_count = cur_ff.pkt_count + 2'h1;
        // Free slot left: hand the flag straight back to firmware
        nxt_st.in_packet_loaded = (cur_ff.pkt_count + 2'h1) >= slots;
      end
    end

    // Held packet is released at frame start
    if (sof_received && cur_ff.hold_pending) begin
      nxt_st.hold_pending = 1'b0;
      nxt_st.pkt_count = cur_ff.pkt_count + 2'h1;
      nxt_st.in_packet_loaded = (cur_ff.pkt_count + 2'h1) >= slots;
    end

    // Token handling
    if (tok_take) begin
      nxt_st.reply_valid = 1'b1;
      nxt_st.reply_data1 = cur_ff.toggle;
      if (tok_stall) begin
        nxt_st.reply_kind = UIEC_REPLY_STALL;
        stall_evt = 1'b1;
        nxt_st.stall_was_sent = 1'b1;
        nxt_st.pkt_count = 2'h0;
        nxt_st.in_packet_loaded = 1'b0;
        nxt_st.hold_pending = 1'b0;
      end else if (tok_data) begin
        nxt_st.reply_kind = UIEC_REPLY_DATA;
        if (cur_ff.iso) begin
          // No handshake in isochronous transfers
          sent_evt = 1'b1;
          nxt_st.toggle = !cur_ff.toggle;
        end else begin
          nxt_st.await_hs = 1'b1;
        end
      end else if (tok_zlp) begin
        nxt_st.reply_kind = UIEC_REPLY_ZLP;
        underrun_evt = 1'b1;
      end else if (tok_nak) begin
        nxt_st.reply_kind = UIEC_REPLY_NAK;
        underrun_evt = 1'b1;
      end
    end

    // Either outcome ends the wait; only a sent packet moves the toggle
    if (hs_sent || hs_retry) begin
      nxt_st.await_hs = 1'b0;
    end
    if (hs_sent) begin
      nxt_st.toggle = !cur_ff.toggle;
      sent_evt = 1'b1;
    end

    if (sent_evt) begin
      // Load in the same cycle already counted above; remove the sent one
      nxt_st.pkt_count = nxt_st.pkt_count - 2'h1;
      nxt_st.in_packet_loaded = fw_load && ((nxt_st.pkt_count) >= slots);
    end

    // Hardware sets beat firmware clears in the same cycle
    if (underrun_evt) begin
      nxt_st.in_underrun_flag = 1'b1;
    end
    irq_set[UIEC_IRQ_SENT] = sent_evt;
    irq_set[UIEC_IRQ_UNDERRUN] = underrun_evt;
    irq_set[UIEC_IRQ_STALL] = stall_evt;
    if (wr_stat) begin
      nxt_st.irq_status = cur_ff.irq_status & ~hwdata[UIEC_IRQ_BITS-1:0];
    end
    nxt_st.irq_status = nxt_st.irq_status | irq_set;
    nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);

    // Direction and FIFO layout
    nxt_st.fifo_split = nxt_st.split;
    nxt_st.in_fifo_upper_half = nxt_st.split;
    nxt_st.endpoint_is_in = nxt_st.split ? 1'b1 : nxt_st.endpoint_direction_pick;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.reply_kind <= UIEC_REPLY_DATA;
      cur_ff.bus_ready <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign hreadyout = cur_ff.bus_ready;
  assign hresp = cur_ff.bus_error;
  assign hrdata = cur_ff.rdata;
  assign irq = cur_ff.irq;
  assign reply_valid = cur_ff.reply_valid;
  assign reply_kind = cur_ff.reply_kind;
  assign reply_data1 = cur_ff.reply_data1;
  assign endpoint_is_in = cur_ff.endpoint_is_in;
  assign in_fifo_upper_half = cur_ff.in_fifo_upper_half;
  assign fifo_split = cur_ff.fifo_split;

endmodule

`default_nettype wire

// ### testbench/uiec_in_endpoint_assertions.sv
// Port checker for the IN endpoint control block.
// Bound to uiec_in_endpoint; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module uiec_in_endpoint_assertions
  import uiec_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic in_token,
  input wire logic ack_received,
  input wire logic ack_timeout,
  input wire logic reply_valid,
  input wire uiec_reply_type reply_kind,
  input wire logic reply_data1,
  input wire logic endpoint_is_in,
  input wire logic in_fifo_upper_half,
  input wire logic fifo_split
);
  logic pend_ff;
  // Only tells when a handshake is owed; an iso data reply merely weakens the check
  always_ff @(posedge clock) begin
    if (rst || ack_received || ack_timeout) pend_ff <= 1'b0;
    else if (reply_valid && reply_kind == UIEC_REPLY_DATA) pend_ff <= 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_reply_cause: assert property (reply_valid |-> $past(in_token))
    else $error("reply without a token");
  a_token_answer: assert property (in_token && !pend_ff && !reply_valid && !ack_received && !ack_timeout
    |=> reply_valid) else $error("token not answered next cycle");
  a_reply_single: assert property (reply_valid && !in_token |=> !reply_valid)
    else $error("reply pulse too long");
  a_kind_holds: assert property (!reply_valid |-> $stable(reply_kind) && $stable(reply_data1))
    else $error("reply fields moved without a reply");
  a_split_upper: assert property (in_fifo_upper_half == fifo_split)
    else $error("upper half does not follow split");
  a_split_in: assert property (fifo_split |-> endpoint_is_in)
    else $error("split endpoint not IN");
  a_rdata_holds: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
endmodule
bind uiec_in_endpoint uiec_in_endpoint_assertions chk (.clock, .rst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .in_token, .ack_received, .ack_timeout, .reply_valid, .reply_kind,
  .reply_data1, .endpoint_is_in, .in_fifo_upper_half, .fifo_split);
`default_nettype wire

// ### testbench/uiec_host_model.sv
// Host side model: IN tokens, handshakes and frame starts as one-cycle pulses.
// Assumes send() is called right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module uiec_host_model (
  input wire logic clock,
  output logic in_token,
  output logic ack_received,
  output logic ack_timeout,
  output logic sof_received
);
  logic [3:0] ev = 4'h0;
  assign {sof_received, ack_timeout, ack_received, in_token} = ev;
  // 0 token, 1 ack, 2 no ack, 3 frame start
  task automatic send(input int k);
    ev <= 4'h1 << k;
    @(posedge clock);
    ev <= 4'h0;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the IN endpoint block over AHB-Lite.
// Assumes the host model pulses the serial engine inputs.
`timescale 1ns/1ps
`default_nettype none
module tb
  import uiec_pkg::*;
;
  logic clock, rst, hsel, hwrite, hreadyout, hresp, irq, reply_valid, reply_data1;
  logic endpoint_is_in, in_fifo_upper_half, fifo_split, in_token, ack_received, ack_timeout, sof_received;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, seed, q;
  uiec_reply_type reply_kind;
  int num_errors, tests_run;
  uiec_in_endpoint uut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .irq, .in_token, .ack_received, .ack_timeout, .sof_received,
    .reply_valid, .reply_kind, .reply_data1, .endpoint_is_in, .in_fifo_upper_half, .fifo_split);
  uiec_host_model host (.clock, .in_token, .ack_received, .ack_timeout, .sof_received);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task wt;
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        num_errors++;
        summarize();
      end
      @(posedge clock);
    end
  endtask
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
    // Deselect between transfers so the select input is exercised
    hsel <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
    bus(1'b0, idx, 32'h0);
    chk(nm, q, exp);
  endtask
  task reply(input uiec_reply_type k, input logic d1);
    host.send(0);
    #1;
    chk("reply", {reply_valid, reply_kind}, {1'b1, k});
    if (k == UIEC_REPLY_DATA) chk("data pid", reply_data1, d1);
    @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata, num_errors, tests_run} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    seed = 32'h37304e8d;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(8'h12, 32'h0, "high reset");
    rd(8'h13, 32'h0, "unmapped");
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      bus(1'b1, 8'h12, seed);
      rd(8'h12, seed & 32'hec, "high byte");
      chk("is_in", endpoint_is_in, seed[2] | seed[5]);
      chk("split", {fifo_split, in_fifo_upper_half}, {2{seed[2]}});
    end
    $display("test registers done");
    bus(1'b1, 8'h12, 32'h0);
    bus(1'b1, 8'h21, 32'h7);
    reply(UIEC_REPLY_NAK, 1'b0);
    rd(8'h20, 32'h2, "irq status");
    chk("irq on", irq, 1'b1);
    bus(1'b1, 8'h21, 32'h0);
    rd(8'h11, 32'h4, "underrun kept");
    chk("irq masked", irq, 1'b0);
    bus(1'b1, 8'h21, 32'h7);
    bus(1'b1, 8'h20, 32'h7);
    bus(1'b1, 8'h11, 32'h0);
    rd(8'h11, 32'h0, "underrun cleared");
    chk("irq cleared", irq, 1'b0);
    bus(1'b1, 8'h11, 32'h1);
    rd(8'h11, 32'h3, "loaded");
    reply(UIEC_REPLY_DATA, 1'b0);
    host.send(1);
    rd(8'h11, 32'h0, "sent");
    rd(8'h20, 32'h1, "sent irq");
    bus(1'b1, 8'h20, 32'h7);
    bus(1'b1, 8'h11, 32'h1);
    reply(UIEC_REPLY_DATA, 1'b1);
    host.send(2);
    @(posedge clock);
    reply(UIEC_REPLY_DATA, 1'b1);
    host.send(1);
    bus(1'b1, 8'h12, 32'h8);
    bus(1'b1, 8'h11, 32'h1);
    reply(UIEC_REPLY_DATA, 1'b0);
    host.send(2);
    rd(8'h11, 32'h0, "forced sent");
    bus(1'b1, 8'h11, 32'h1);
    reply(UIEC_REPLY_DATA, 1'b1);
    host.send(1);
    $display("test bulk done");
    bus(1'b1, 8'h12, 32'h80);
    bus(1'b1, 8'h11, 32'h1);
    rd(8'h11, 32'h2, "double free slot");
    bus(1'b1, 8'h11, 32'h1);
    rd(8'h11, 32'h3, "double full");
    bus(1'b1, 8'h11, 32'h10);
    reply(UIEC_REPLY_STALL, 1'b0);
    rd(8'h11, 32'h30, "stall flushed");
    bus(1'b1, 8'h11, 32'h0);
    bus(1'b1, 8'h12, 32'h40);
    reply(UIEC_REPLY_ZLP, 1'b0);
    rd(8'h11, 32'h4, "iso underrun");
    bus(1'b1, 8'h22, 32'h1);
    bus(1'b1, 8'h11, 32'h0);
    bus(1'b1, 8'h11, 32'h1);
    rd(8'h11, 32'h0, "held");
    host.send(3);
    rd(8'h11, 32'h3, "after frame");
    $display("test modes done");
    summarize();
  end
endmodule
`default_nettype wire
